//--- design/cidd_cfg.svh
`ifndef CIDD_CFG_SVH
`define CIDD_CFG_SVH

// register byte addresses (printed offsets are not all multiples of four)
`define CIDD_IDX_CONTROL     8'h29
`define CIDD_IDX_STATUS      8'h2A
`define CIDD_IDX_PACKED      8'h2B
`define CIDD_ADDR_CONTROL    12'h0A4
`define CIDD_ADDR_STATUS     12'h0A8
`define CIDD_ADDR_PACKED     12'h0AC

// control fields
`define CIDD_CTL_PWDN        0
`define CIDD_CTL_BYTE_MSK    2
`define CIDD_CTL_RING_MSK    3
`define CIDD_CTL_CARR_MSK    4
`define CIDD_CTL_SRC_SEL     5
`define CIDD_CTL_WMASK       8'h3D
`define CIDD_CTL_RESET       8'h3D

// status fields
`define CIDD_STS_RING_PEND   0
`define CIDD_STS_CARR_PEND   1
`define CIDD_STS_RAW_BIT     2
`define CIDD_STS_COOKED_BIT  3
`define CIDD_STS_BYTE_RDY    5
`define CIDD_STS_RING_PRES   6

// serial character framing
`define CIDD_CHAR_BITS       10
`define CIDD_DATA_BITS       8

// baud rate of the decoded stream, in bits per second
`define CIDD_BAUD_BPS        1200
`define CIDD_CLK_HZ          40000000
`define CIDD_BIT_CYCLES      (`CIDD_CLK_HZ / `CIDD_BAUD_BPS)

`endif

//--- design/cidd_ctrl.sv
// Notes on behaviour
// - three event sources: ring/reversal, carrier, packed byte.
// - each source has a mask bit; 0 enables, 1 disables.
// - pending flag is set on every event, masked or not.
// - unmasked pending raises the request only with peripheral enable; vector 10H.
// - a set pending flag inhibits further interrupts from that source.
// - power-down stops decoder functions; registers stay accessible.
// - control bit 0 is power down; bit 1 unused.
// - control at 29H: byte mask bit 2, ring mask bit 3.
// - control bit 5 picks cooked (1) or raw (0) stream for packer.
// - status bits 0,1,5 are ring, carrier pending and byte ready.
// - status bit 2 mirrors raw stream, bit 3 the cooked stream.
// - status bit 6 shows live ring-present signal.
// - read-only register at 2BH returns last packed byte.
// - ring pending is set on falling edge of ring_detect_n.
// - ring interrupt needs mask 0 and peripheral enable 1.
// - high ring-detect input drives ring_detect_n low.
// - carrier detect sets carrier pending.
// - packer takes 10-bit characters, drops first and tenth bits.
// - a character starts only on a 0 start bit.
// - with no modulated data both stream bits read 1.
`timescale 1ns/1ps
`include "cidd_cfg.svh"

module cidd_ctrl #(
    parameter int BIT_CYCLES = `CIDD_BIT_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        raw_stream_i,
    input  wire logic        cooked_stream_i,
    input  wire logic        carrier_detect_i,
    input  wire logic        ring_detect_input_i,
    input  wire logic        peripheral_irq_enable_i,
    output logic             peripheral_request_o,
    output logic             decoder_power_down_o
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    // control register fields
    logic       decoder_power_down;
    logic       byte_irq_mask;
    logic       ring_irq_mask;
    logic       carrier_irq_mask;
    logic       packer_source_select;
    // status flags
    logic       ring_pending;
    logic       carrier_pending;
    logic       byte_ready;
    logic [7:0] packed_byte;

    cidd_pkg::cidd_line_t line_sync;
    cidd_pkg::cidd_pk_state_t pk_state;

    // line inputs cross from the analog side
    cidd_sync #(.RESET_VAL(1'b1)) u_sync_raw (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (raw_stream_i),
        .sync_o    (line_sync.raw_bit)
    );
    cidd_sync #(.RESET_VAL(1'b1)) u_sync_cooked (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (cooked_stream_i),
        .sync_o    (line_sync.cooked_bit)
    );
    cidd_sync #(.RESET_VAL(1'b0)) u_sync_carrier (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (carrier_detect_i),
        .sync_o    (line_sync.carrier)
    );
    cidd_sync #(.RESET_VAL(1'b0)) u_sync_ring (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (ring_detect_input_i),
        .sync_o    (line_sync.ring_level)
    );

    // decoder view of the line; idle marks while powered down
    logic raw_bit;
    logic cooked_bit;
    logic carrier_seen;
    logic ring_detect_n;
    logic ring_detect_n_q;
    logic carrier_q;
    logic packer_bit;

    assign raw_bit       = decoder_power_down | line_sync.raw_bit;
    assign cooked_bit    = decoder_power_down | line_sync.cooked_bit;
    assign carrier_seen  = ~decoder_power_down & line_sync.carrier;
    // ring detect keeps working in power down
    assign ring_detect_n = ~line_sync.ring_level;
    assign packer_bit    = packer_source_select ? cooked_bit : raw_bit;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ring_detect_n_q <= 1'b1;
            carrier_q       <= 1'b0;
        end else begin
            ring_detect_n_q <= ring_detect_n;
            carrier_q       <= carrier_seen;
        end
    end

    logic ring_event;
    logic carrier_event;
    logic byte_event;

    assign ring_event    = ring_detect_n_q & ~ring_detect_n;
    assign carrier_event = carrier_seen & ~carrier_q;

    // packer: sample mid-bit after a 0 start bit
    logic [CW-1:0] bit_cnt;
    logic [3:0]    bit_idx;
    logic [8:0]    shreg;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pk_state <= cidd_pkg::CIDD_PK_IDLE;
            bit_cnt  <= '0;
            bit_idx  <= 4'h0;
            shreg    <= 9'h000;
        end else if (decoder_power_down) begin
            pk_state <= cidd_pkg::CIDD_PK_IDLE;
            bit_cnt  <= '0;
            bit_idx  <= 4'h0;
        end else begin
            case (pk_state)
                cidd_pkg::CIDD_PK_IDLE: begin
                    if (!packer_bit) begin
                        pk_state <= cidd_pkg::CIDD_PK_SHIFT;
                        bit_cnt  <= CW'(BIT_CYCLES / 2);
                        bit_idx  <= 4'h0;
                    end
                end
                cidd_pkg::CIDD_PK_SHIFT: begin
                    if (bit_cnt == '0) begin
                        bit_cnt <= CW'(BIT_CYCLES - 1);
                        if (bit_idx == 4'h0 && packer_bit) begin
                            // glitch, not a real start bit
                            pk_state <= cidd_pkg::CIDD_PK_IDLE;
                        end else begin
                            if (bit_idx != 4'h0) begin
                                shreg <= {packer_bit, shreg[8:1]};
                            end
                            if (bit_idx == 4'(`CIDD_CHAR_BITS - 1)) begin
                                pk_state <= cidd_pkg::CIDD_PK_IDLE;
                            end
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end else begin
                        bit_cnt <= bit_cnt - CW'(1);
                    end
                end
                default: pk_state <= cidd_pkg::CIDD_PK_IDLE;
            endcase
        end
    end

    // shreg[8:1] holds the data; the stop bit is only shifted in during this same cycle
    assign byte_event = ~decoder_power_down && pk_state == cidd_pkg::CIDD_PK_SHIFT
                        && bit_cnt == '0
                        && bit_idx == 4'(`CIDD_CHAR_BITS - 1);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            packed_byte <= 8'h00;
        end else if (byte_event) begin
            // first (start) and tenth (stop) bits are dropped
            packed_byte <= shreg[8:1];
        end
    end

    // APB access: zero wait states, error on unmapped address
    logic apb_access;
    logic wr_en;
    logic hit_ctl;
    logic hit_sts;
    logic hit_pkd;
    logic mapped;

    assign hit_ctl    = paddr_i == `CIDD_ADDR_CONTROL;
    assign hit_sts    = paddr_i == `CIDD_ADDR_STATUS;
    assign hit_pkd    = paddr_i == `CIDD_ADDR_PACKED;
    assign mapped     = hit_ctl | hit_sts | hit_pkd;
    assign apb_access = psel_i & penable_i;
    assign wr_en      = apb_access & pwrite_i & pstrb_i[0] & mapped;
    assign pready_o   = psel_i & penable_i;
    assign pslverr_o  = apb_access & ~mapped;

    logic ctl_wr;
    assign ctl_wr = wr_en & hit_ctl;

    // decoder starts powered down so floating stream and carrier lines cannot raise flags; ring pending still can
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            decoder_power_down <= 1'b1;
        end else if (ctl_wr) begin
            decoder_power_down <= pwdata_i[`CIDD_CTL_PWDN];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            byte_irq_mask <= 1'b1;
        end else if (ctl_wr) begin
            byte_irq_mask <= pwdata_i[`CIDD_CTL_BYTE_MSK];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ring_irq_mask <= 1'b1;
        end else if (ctl_wr) begin
            ring_irq_mask <= pwdata_i[`CIDD_CTL_RING_MSK];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carrier_irq_mask <= 1'b1;
        end else if (ctl_wr) begin
            carrier_irq_mask <= pwdata_i[`CIDD_CTL_CARR_MSK];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            packer_source_select <= 1'b1;
        end else if (ctl_wr) begin
            packer_source_select <= pwdata_i[`CIDD_CTL_SRC_SEL];
        end
    end

    // set wins over a software clear in the same cycle
    logic sts_wr;
    assign sts_wr = wr_en & hit_sts;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ring_pending <= 1'b0;
        end else if (ring_event) begin
            ring_pending <= 1'b1;
        end else if (sts_wr) begin
            ring_pending <= pwdata_i[`CIDD_STS_RING_PEND];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            carrier_pending <= 1'b0;
        end else if (carrier_event) begin
            carrier_pending <= 1'b1;
        end else if (sts_wr) begin
            carrier_pending <= pwdata_i[`CIDD_STS_CARR_PEND];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            byte_ready <= 1'b0;
        end else if (byte_event) begin
            byte_ready <= 1'b1;
        end else if (sts_wr) begin
            byte_ready <= pwdata_i[`CIDD_STS_BYTE_RDY];
        end
    end

    logic [7:0] ctl_view;
    logic [7:0] sts_view;

    always_comb begin
        ctl_view = 8'h00;
        ctl_view[`CIDD_CTL_PWDN]     = decoder_power_down;
        ctl_view[`CIDD_CTL_BYTE_MSK] = byte_irq_mask;
        ctl_view[`CIDD_CTL_RING_MSK] = ring_irq_mask;
        ctl_view[`CIDD_CTL_CARR_MSK] = carrier_irq_mask;
        ctl_view[`CIDD_CTL_SRC_SEL]  = packer_source_select;
        sts_view = 8'h00;
        sts_view[`CIDD_STS_RING_PEND]  = ring_pending;
        sts_view[`CIDD_STS_CARR_PEND]  = carrier_pending;
        sts_view[`CIDD_STS_RAW_BIT]    = raw_bit;
        sts_view[`CIDD_STS_COOKED_BIT] = cooked_bit;
        sts_view[`CIDD_STS_BYTE_RDY]   = byte_ready;
        sts_view[`CIDD_STS_RING_PRES]  = ~ring_detect_n;
    end

    // read data registered in the setup cycle so it is stable in access
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (hit_ctl) begin
                prdata_o <= {24'h00_0000, ctl_view};
            end else if (hit_sts) begin
                prdata_o <= {24'h00_0000, sts_view};
            end else if (hit_pkd) begin
                prdata_o <= {24'h00_0000, packed_byte};
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // request pulses one cycle on each rise of an unmasked pending flag while peripheral enable is 1; a held flag cannot re-fire
    logic [2:0] pend_vec;
    logic [2:0] mask_vec;
    logic [2:0] pend_q;
    logic       fire;

    assign pend_vec = {byte_ready, carrier_pending, ring_pending};
    assign mask_vec = {byte_irq_mask, carrier_irq_mask, ring_irq_mask};
    // fresh rise of an enabled pending flag; while it stays set nothing repeats
    assign fire = |(pend_vec & ~pend_q & ~mask_vec) & peripheral_irq_enable_i;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q               <= 3'h0;
            peripheral_request_o <= 1'b0;
        end else begin
            pend_q               <= pend_vec;
            peripheral_request_o <= fire;
        end
    end

    assign decoder_power_down_o = decoder_power_down;
endmodule : cidd_ctrl

//--- design/cidd_pkg.sv
package cidd_pkg;

    typedef struct packed {
        logic raw_bit;
        logic cooked_bit;
        logic carrier;
        logic ring_level;
    } cidd_line_t;

    typedef struct packed {
        logic       sel;
        logic       enable;
        logic       write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cidd_apb_req_t;

    typedef enum logic [1:0] {
        CIDD_PK_IDLE,
        CIDD_PK_SHIFT
    } cidd_pk_state_t;

endpackage : cidd_pkg

//--- design/cidd_sync.sv
`timescale 1ns/1ps
`include "cidd_cfg.svh"

// three-stage synchroniser; a change counts once stages two and three agree
module cidd_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_o <= RESET_VAL;
        end else if (s2 == s3) begin
            sync_o <= s3;
        end
    end
endmodule : cidd_sync

//--- verif/cidd_ctrl_properties.sv
`timescale 1ns/1ps
`include "cidd_cfg.svh"
module cidd_ctrl_properties #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        raw_stream_i,
    input wire logic        cooked_stream_i,
    input wire logic        carrier_detect_i,
    input wire logic        ring_detect_input_i,
    input wire logic        peripheral_irq_enable_i,
    input wire logic        peripheral_request_o,
    input wire logic        decoder_power_down_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic rd_setup;
    logic mapped;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign mapped = paddr_i inside {`CIDD_ADDR_CONTROL, `CIDD_ADDR_STATUS, `CIDD_ADDR_PACKED};
    property p_ready;
        pready_o == (psel_i && penable_i);
    endproperty
    a_ready: assert property (p_ready) else $error("pready off");
    property p_pwdn;
        psel_i && penable_i && pwrite_i && pstrb_i[0] && paddr_i == `CIDD_ADDR_CONTROL
            |=> decoder_power_down_o == $past(pwdata_i[0]);
    endproperty
    a_pwdn: assert property (p_pwdn) else $error("power down bit");
    property p_ctl_zero;
        rd_setup && paddr_i == `CIDD_ADDR_CONTROL |=> prdata_o[7:6] == 2'h0 && !prdata_o[1];
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control unused bit");
    property p_sts_zero;
        rd_setup && paddr_i == `CIDD_ADDR_STATUS |=> !prdata_o[7] && !prdata_o[4];
    endproperty
    a_sts_zero: assert property (p_sts_zero) else $error("status unused bit");
    property p_idle_pd;
        decoder_power_down_o && rd_setup && paddr_i == `CIDD_ADDR_STATUS
            |=> prdata_o[3:2] == 2'h3;
    endproperty
    a_idle_pd: assert property (p_idle_pd) else $error("stream bits in power down");
    property p_ring_pres;
        ring_detect_input_i [*6] ##0 (rd_setup && paddr_i == `CIDD_ADDR_STATUS) |=> prdata_o[6];
    endproperty
    a_ring_pres: assert property (p_ring_pres) else $error("ring present");
    property p_req_en;
        peripheral_request_o |-> $past(peripheral_irq_enable_i);
    endproperty
    a_req_en: assert property (p_req_en) else $error("request while disabled");
    property p_unmapped;
        psel_i && !penable_i && !pwrite_i && !mapped |=> pslverr_o && prdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : cidd_ctrl_properties

//--- verif/cidd_ctrl_tb.sv
`timescale 1ns/1ps
`include "cidd_cfg.svh"
module cidd_ctrl_tb;
    localparam int BIT_CYCLES = 8;
    logic                 mclk_i = 1'h0;
    logic                 reset_n_i = 1'h0;
    logic                 psel = 1'h0;
    logic                 penable = 1'h0;
    logic                 pwrite = 1'h0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic [3:0]           pstrb = 4'hF;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq_en = 1'h0;
    logic                 req;
    logic                 pwdn;
    cidd_pkg::cidd_line_t line;
    logic [31:0]          rdata;
    logic                 perr;
    int                   errors = 0;
    int                   comparisons = 0;
    int                   irqs = 0;
    int                   cycles = 0;

    cidd_ctrl #(.BIT_CYCLES(BIT_CYCLES)) i_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .raw_stream_i(line.raw_bit), .cooked_stream_i(line.cooked_bit),
        .carrier_detect_i(line.carrier), .ring_detect_input_i(line.ring_level),
        .peripheral_irq_enable_i(irq_en), .peripheral_request_o(req),
        .decoder_power_down_o(pwdn)
    );
    cidd_line_model #(.BIT_CYCLES(BIT_CYCLES)) i_line (.mclk_i(mclk_i), .line_o(line));

    always #12.5 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        cycles++;
        if (req === 1'h1) irqs++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // idle edge first so a release is never overwritten in its own time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk_i);
        penable <= 1'h1;
        do @(posedge mclk_i); while (pready !== 1'h1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk(rdata, {24'h0, e});
    endtask : rd

    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'h1;
        rd(`CIDD_ADDR_CONTROL, 8'h3D);
        rd(`CIDD_ADDR_STATUS, 8'h0C);
        rd(`CIDD_ADDR_PACKED, 8'h00);
        apb(1'h0, 12'h0B0, 8'h00);
        chk({31'h0, perr}, 32'h1);
        apb(1'h1, `CIDD_ADDR_CONTROL, 8'hFF);
        rd(`CIDD_ADDR_CONTROL, 8'h3D);
        i_line.set_line(1'h0, 1'h1);
        repeat (8) @(posedge mclk_i);
        rd(`CIDD_ADDR_STATUS, 8'h4D);
        chk(irqs, 32'h0);
        i_line.set_line(1'h0, 1'h0);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        irq_en <= 1'h1;
        apb(1'h1, `CIDD_ADDR_CONTROL, 8'h00);
        rd(`CIDD_ADDR_STATUS, 8'h0C);
        i_line.set_line(1'h0, 1'h1);
        repeat (8) @(posedge mclk_i);
        chk(irqs, 32'h1);
        i_line.set_line(1'h0, 1'h0);
        repeat (8) @(posedge mclk_i);
        i_line.set_line(1'h0, 1'h1);
        repeat (8) @(posedge mclk_i);
        chk(irqs, 32'h1);
        i_line.set_line(1'h0, 1'h0);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        irq_en <= 1'h0;
        i_line.set_line(1'h1, 1'h0);
        repeat (8) @(posedge mclk_i);
        rd(`CIDD_ADDR_STATUS, 8'h0E);
        chk(irqs, 32'h1);
        i_line.set_line(1'h0, 1'h0);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        irq_en <= 1'h1;
        i_line.set_line(1'h1, 1'h0);
        repeat (8) @(posedge mclk_i);
        chk(irqs, 32'h2);
        i_line.set_line(1'h0, 1'h0);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        i_line.send_char(8'hA5, 1'h1, 1'h0);
        repeat (16) @(posedge mclk_i);
        rd(`CIDD_ADDR_PACKED, 8'hA5);
        rd(`CIDD_ADDR_STATUS, 8'h2C);
        chk(irqs, 32'h3);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        i_line.send_char(8'h3C, 1'h0, 1'h1);
        repeat (16) @(posedge mclk_i);
        rd(`CIDD_ADDR_STATUS, 8'h0C);
        apb(1'h1, `CIDD_ADDR_CONTROL, 8'h24);
        i_line.send_char(8'h3C, 1'h0, 1'h1);
        repeat (16) @(posedge mclk_i);
        rd(`CIDD_ADDR_PACKED, 8'h3C);
        chk(irqs, 32'h3);
        apb(1'h1, `CIDD_ADDR_CONTROL, 8'h20);
        i_line.send_char(8'h42, 1'h1, 1'h1);
        repeat (16) @(posedge mclk_i);
        rd(`CIDD_ADDR_PACKED, 8'h42);
        chk(irqs, 32'h3);
        apb(1'h1, `CIDD_ADDR_STATUS, 8'h00);
        apb(1'h1, `CIDD_ADDR_CONTROL, 8'h21);
        i_line.send_char(8'h99, 1'h1, 1'h1);
        i_line.set_line(1'h1, 1'h0);
        repeat (16) @(posedge mclk_i);
        rd(`CIDD_ADDR_PACKED, 8'h42);
        rd(`CIDD_ADDR_STATUS, 8'h0C);
        close_out();
    end
endmodule : cidd_ctrl_tb

bind cidd_ctrl cidd_ctrl_properties #(.BIT_CYCLES(BIT_CYCLES)) i_props (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .raw_stream_i(raw_stream_i), .cooked_stream_i(cooked_stream_i),
    .carrier_detect_i(carrier_detect_i), .ring_detect_input_i(ring_detect_input_i),
    .peripheral_irq_enable_i(peripheral_irq_enable_i),
    .peripheral_request_o(peripheral_request_o), .decoder_power_down_o(decoder_power_down_o)
);

//--- verif/cidd_line_model.sv
`timescale 1ns/1ps
module cidd_line_model #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic           mclk_i,
    output cidd_pkg::cidd_line_t line_o
);
    initial line_o = 4'hC;
    // both streams rest at mark between frames, never toggling
    task automatic send_char(input logic [7:0] d, input logic on_raw, input logic on_cooked);
        logic [9:0] f;
        f = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_i);
            line_o.raw_bit <= on_raw ? f[i] : 1'h1;
            line_o.cooked_bit <= on_cooked ? f[i] : 1'h1;
            repeat (BIT_CYCLES - 1) @(posedge mclk_i);
        end
    endtask : send_char
    task automatic set_line(input logic carrier, input logic ring);
        @(posedge mclk_i);
        line_o.carrier <= carrier;
        line_o.ring_level <= ring;
    endtask : set_line
endmodule : cidd_line_model
